// ===== aesc_coprocessor.sv
// block cipher coprocessor behind control/status, input and output port registers
//
// What this block does
// - works on whole 128-bit blocks in CBC, ECB and MAC modes
// - status by CPU, data ports via DMA
// - start write raises a DMA request
// - block completion sets flag; enable gates irq
// - stream modes use four 32-bit segments
// - own DMA requests pace the segments
// - CTR mode increments a 32-bit counter
// - two DMA requests: input and output
// - mode field bits 6:4 selects cipher mode
// - bit 7 always reads zero
// - command field selects encrypt/decrypt/key/IV
// - start launches command, hardware clears it
// - ready low while block runs, resets high
// - key/IV load aborts; reset clears them
`timescale 1ns/1ps
`include "aesc_params.svh"

module aesc_coprocessor (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // register accesses
  input  wire aesc_pkg::aesc_sfr_req_t sfrReq,
  output logic [7:0]                  csRdata,
  output logic [7:0]                  outPortData,
  // DMA requests
  output logic                        inputDmaRequest,
  output logic                        outputDmaRequest,
  // interrupt
  input  wire logic                   cipherIrqEnable,
  input  wire logic                   cipherIrqFlagClear,
  output logic                        cipherIrqFlag,
  output logic                        cipherIrq
);
  import aesc_pkg::*;

  aesc_state_t  s_r;
  aesc_state_t  s_nxt;
  logic         coreStart;
  logic         coreAbort;
  logic         coreDecrypt;
  logic [127:0] coreIn;
  logic         coreDone;
  logic [127:0] coreOut;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic isStream(input logic [2:0] m);
    isStream = (m == AESC_MODE_CFB) || (m == AESC_MODE_OFB) || (m == AESC_MODE_CTR);
  endfunction : isStream

  function automatic logic isCipherCmd(input aesc_cmd_t c);
    isCipherCmd = (c == AESC_CMD_ENC) || (c == AESC_CMD_DEC);
  endfunction : isCipherCmd

  function automatic logic [31:0] ksPart(input logic [127:0] k, input logic [1:0] seg);
    unique case (seg)
      2'h0: ksPart = k[127:96];
      2'h1: ksPart = k[95:64];
      2'h2: ksPart = k[63:32];
      2'h3: ksPart = k[31:0];
    endcase
  endfunction : ksPart

  function automatic logic segmented(input aesc_state_t st);
    segmented = isStream(st.mode) && isCipherCmd(st.cmd);
  endfunction : segmented

  ////////////////////////////////////////////////////////////////////////////
  aesc_round_core u_core (
    .clk     (clk),
    .rst     (rst),
    .start   (coreStart),
    .abort   (coreAbort),
    .decrypt (coreDecrypt),
    .key     (s_r.key),
    .din     (coreIn),
    .done    (coreDone),
    .dout    (coreOut)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [3:0]  lastCnt;
    logic [31:0] segIn;
    logic [31:0] segOut;
    s_nxt       = s_r;
    coreStart   = 1'b0;
    coreAbort   = 1'b0;
    coreDecrypt = 1'b0;
    coreIn      = s_r.inBuf;
    lastCnt     = segmented(s_r) ? `AESC_SEG_BYTES : `AESC_BLOCK_BYTES;
    segIn       = s_r.inBuf[31:0];
    segOut      = segIn ^ ksPart(s_r.ks, s_r.segCnt);
    // software clear loses to a completion in the same cycle
    s_nxt.irqFlag = s_r.irqFlag & ~cipherIrqFlagClear;

    if (sfrReq.csWrite) begin
      s_nxt.mode = sfrReq.csWdata[`AESC_MODE_MSB:`AESC_MODE_LSB];
      s_nxt.cmd  = aesc_cmd_t'(sfrReq.csWdata[`AESC_CMD_MSB:`AESC_CMD_LSB]);
      if (sfrReq.csWdata[`AESC_START_BIT]) begin
        s_nxt.start  = 1'b1;
        s_nxt.phase  = PH_LOAD;
        s_nxt.cnt    = 4'h0;
        s_nxt.segCnt = 2'h0;
        s_nxt.inReq  = 1'b1;
        s_nxt.outReq = 1'b0;
        if (isCipherCmd(s_nxt.cmd)) begin
          s_nxt.rdy = 1'b0;
        end else begin
          // a key or IV load throws away whatever block was in flight
          coreAbort = 1'b1;
          s_nxt.rdy = 1'b1;
        end
      end
    end else begin
      unique case (s_r.phase)
        PH_IDLE: begin
        end
        PH_LOAD: begin
          if (sfrReq.inPortWrite) begin
            s_nxt.inBuf = {s_r.inBuf[119:0], sfrReq.inPortData};
            s_nxt.cnt   = s_r.cnt + 4'h1;
            if (s_r.cnt == lastCnt) begin
              s_nxt.inReq = 1'b0;
              s_nxt.cnt   = 4'h0;
              segIn       = s_nxt.inBuf[31:0];
              segOut      = segIn ^ ksPart(s_r.ks, s_r.segCnt);
              unique case (s_r.cmd)
                AESC_CMD_KEY: begin
                  s_nxt.key   = s_nxt.inBuf;
                  s_nxt.start = 1'b0;
                  s_nxt.phase = PH_IDLE;
                end
                AESC_CMD_IV: begin
                  s_nxt.iv    = s_nxt.inBuf;
                  s_nxt.start = 1'b0;
                  s_nxt.phase = PH_IDLE;
                end
                default: begin
                  if (segmented(s_r) && s_r.segCnt != 2'h0) begin
                    // later segments reuse the key stream already computed
                    s_nxt.outBuf = {segOut, 96'h0};
                    s_nxt.cfbAcc = {s_r.cfbAcc[95:0], (s_r.cmd == AESC_CMD_DEC) ? segIn : segOut};
                    s_nxt.outReq = 1'b1;
                    s_nxt.phase  = PH_OUT;
                  end else begin
                    coreStart = 1'b1;
                    if (segmented(s_r)) begin
                      coreIn = s_r.iv;
                    end else if (s_r.cmd == AESC_CMD_DEC &&
                                 (s_r.mode == AESC_MODE_CBC || s_r.mode == AESC_MODE_MAC ||
                                  s_r.mode == AESC_MODE_ECB)) begin
                      coreIn      = s_nxt.inBuf;
                      coreDecrypt = 1'b1;
                    end else if (s_r.mode == AESC_MODE_ECB) begin
                      coreIn = s_nxt.inBuf;
                    end else begin
                      coreIn = s_nxt.inBuf ^ s_r.iv;
                    end
                    s_nxt.phase = PH_RUN;
                  end
                end
              endcase
            end
          end
        end
        PH_RUN: begin
          if (coreDone) begin
            s_nxt.outReq = 1'b1;
            s_nxt.phase  = PH_OUT;
            if (segmented(s_r)) begin
              s_nxt.ks     = coreOut;
              segOut       = segIn ^ coreOut[127:96];
              s_nxt.outBuf = {segOut, 96'h0};
              s_nxt.cfbAcc = {s_r.cfbAcc[95:0], (s_r.cmd == AESC_CMD_DEC) ? segIn : segOut};
            end else if (s_r.mode == AESC_MODE_ECB) begin
              s_nxt.outBuf = coreOut;
            end else if (s_r.cmd == AESC_CMD_DEC) begin
              s_nxt.outBuf = coreOut ^ s_r.iv;
              s_nxt.iv     = s_r.inBuf;
            end else begin
              // CBC and CBC-MAC chain the cipher output into the next block
              s_nxt.outBuf = coreOut;
              s_nxt.iv     = coreOut;
            end
          end
        end
        PH_OUT: begin
          if (sfrReq.outPortRead) begin
            s_nxt.outBuf = {s_r.outBuf[119:0], 8'h00};
            s_nxt.cnt    = s_r.cnt + 4'h1;
            if (s_r.cnt == lastCnt) begin
              s_nxt.outReq = 1'b0;
              s_nxt.cnt    = 4'h0;
              if (segmented(s_r) && s_r.segCnt != `AESC_LAST_SEG) begin
                s_nxt.segCnt = s_r.segCnt + 2'h1;
                s_nxt.inReq  = 1'b1;
                s_nxt.phase  = PH_LOAD;
              end else begin
                s_nxt.rdy     = 1'b1;
                s_nxt.start   = 1'b0;
                s_nxt.irqFlag = 1'b1;
                s_nxt.phase   = PH_IDLE;
                if (segmented(s_r)) begin
                  unique case (s_r.mode)
                    AESC_MODE_CFB: s_nxt.iv = s_nxt.cfbAcc;
                    AESC_MODE_OFB: s_nxt.iv = s_r.ks;
                    default:       s_nxt.iv = {s_r.iv[127:32], s_r.iv[31:0] + 32'h1};
                  endcase
                end
              end
            end
          end
        end
      endcase
    end

    s_nxt.irq  = s_nxt.irqFlag & cipherIrqEnable;
    s_nxt.dout = s_nxt.outBuf[127:120];
    s_nxt.csRd = {1'b0, s_nxt.mode, s_nxt.rdy, s_nxt.cmd, s_nxt.start};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      // key and IV are wiped here as well, never kept across reset
      s_r       <= '0;
      s_r.rdy   <= `AESC_RDY_RESET;
      s_r.csRd  <= `AESC_CS_RESET;
      s_r.dout  <= `AESC_DOUT_RESET;
      s_r.phase <= PH_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign csRdata          = s_r.csRd;
  assign outPortData      = s_r.dout;
  assign inputDmaRequest  = s_r.inReq;
  assign outputDmaRequest = s_r.outReq;
  assign cipherIrqFlag    = s_r.irqFlag;
  assign cipherIrq        = s_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence seqLaunch;
    sfrReq.csWrite && sfrReq.csWdata[`AESC_START_BIT];
  endsequence

  sequence seqCipherLaunch;
    seqLaunch ##0 !sfrReq.csWdata[`AESC_CMD_MSB];
  endsequence

  a_launch_dma_req: assert property (seqLaunch |=> inputDmaRequest && !outputDmaRequest)
    else $error("start write did not raise the input request");
  a_ready_cleared: assert property (seqCipherLaunch |=> !csRdata[`AESC_RDY_BIT] && csRdata[0])
    else $error("ready not low after a cipher start");
  a_unused_zero: assert property (csRdata[`AESC_UNUSED_BIT] == 1'b0)
    else $error("unused status bit read as one");
  a_mode_readback: assert property (sfrReq.csWrite |=> csRdata[6:4] == $past(sfrReq.csWdata[6:4]))
    else $error("mode field does not read back");
  a_done_sets_flag: assert property ($rose(csRdata[`AESC_RDY_BIT]) && !$past(sfrReq.csWrite)
                                     |-> cipherIrqFlag && !csRdata[0])
    else $error("block completion did not set the flag");
  a_irq_gated: assert property (cipherIrq |-> $past(cipherIrqEnable) && $past(cipherIrqFlag || s_nxt.irqFlag))
    else $error("interrupt raised without enable");
  a_req_exclusive: assert property (!(inputDmaRequest && outputDmaRequest))
    else $error("both DMA requests active");
  a_segment_size: assert property (s_r.phase == PH_LOAD && segmented(s_r) && sfrReq.inPortWrite &&
                                   !sfrReq.csWrite && s_r.cnt == `AESC_SEG_BYTES
                                   |=> !inputDmaRequest ##[1:14] outputDmaRequest)
    else $error("segment not closed after four bytes");
  a_block_size: assert property (s_r.phase == PH_LOAD && !segmented(s_r) && isCipherCmd(s_r.cmd) &&
                                 sfrReq.inPortWrite && !sfrReq.csWrite && s_r.cnt == 4'h3
                                 |=> inputDmaRequest)
    else $error("whole-block mode stopped after one word");
  a_key_abort: assert property (seqLaunch ##0 sfrReq.csWdata[`AESC_CMD_MSB]
                                |=> csRdata[`AESC_RDY_BIT] && !outputDmaRequest)
    else $error("key or IV load did not abort processing");
  a_ctr_increment: assert property (s_r.phase == PH_OUT && s_r.mode == AESC_MODE_CTR && segmented(s_r) &&
                                    s_r.segCnt == `AESC_LAST_SEG && s_r.cnt == `AESC_SEG_BYTES &&
                                    sfrReq.outPortRead && !sfrReq.csWrite
                                    |=> s_r.iv[31:0] == $past(s_r.iv[31:0]) + 32'h1)
    else $error("counter field did not advance by one");

endmodule : aesc_coprocessor

// ===== aesc_params.svh
// register field positions, reset values and timing counts of the cipher block
`ifndef AESC_PARAMS_SVH
`define AESC_PARAMS_SVH

`define AESC_START_BIT    0
`define AESC_CMD_LSB      1
`define AESC_CMD_MSB      2
`define AESC_RDY_BIT      3
`define AESC_MODE_LSB     4
`define AESC_MODE_MSB     6
`define AESC_UNUSED_BIT   7

`define AESC_CS_RESET     8'h08
`define AESC_RDY_RESET    1'h1
`define AESC_DOUT_RESET   8'h00

`define AESC_BLOCK_BYTES  4'hF
`define AESC_SEG_BYTES    4'h3
`define AESC_LAST_SEG     2'h3
`define AESC_CORE_ROUNDS  4'hA

`endif

// ===== aesc_pkg.sv
// types shared by the cipher coprocessor and its round core
package aesc_pkg;

  typedef enum logic [2:0] {
    AESC_MODE_CBC  = 3'h0,
    AESC_MODE_CFB  = 3'h1,
    AESC_MODE_OFB  = 3'h2,
    AESC_MODE_CTR  = 3'h3,
    AESC_MODE_ECB  = 3'h4,
    AESC_MODE_MAC  = 3'h5
  } aesc_mode_t;

  typedef enum logic [1:0] {
    AESC_CMD_ENC   = 2'h0,
    AESC_CMD_DEC   = 2'h1,
    AESC_CMD_KEY   = 2'h2,
    AESC_CMD_IV    = 2'h3
  } aesc_cmd_t;

  typedef enum logic [1:0] {PH_IDLE, PH_LOAD, PH_RUN, PH_OUT} aesc_phase_t;

  // special-function register accesses from the processor or DMA
  typedef struct packed {
    logic       csWrite;
    logic [7:0] csWdata;
    logic       inPortWrite;
    logic [7:0] inPortData;
    logic       outPortRead;
  } aesc_sfr_req_t;

  typedef struct packed {
    logic         busy;
    logic         done;
    logic         decrypt;
    logic [3:0]   round;
    logic [127:0] data;
  } aesc_core_state_t;

  typedef struct packed {
    aesc_phase_t  phase;
    logic [2:0]   mode;
    aesc_cmd_t    cmd;
    logic         start;
    logic         rdy;
    logic         inReq;
    logic         outReq;
    logic         irqFlag;
    logic         irq;
    logic [1:0]   segCnt;
    logic [3:0]   cnt;
    logic [127:0] key;
    logic [127:0] iv;
    logic [127:0] ks;
    logic [127:0] inBuf;
    logic [127:0] outBuf;
    logic [127:0] cfbAcc;
    logic [7:0]   csRd;
    logic [7:0]   dout;
  } aesc_state_t;

endpackage : aesc_pkg

// ===== aesc_round_core.sv
// iterative keyed block transform used by the coprocessor
`timescale 1ns/1ps
`include "aesc_params.svh"

module aesc_round_core (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // control
  input  wire logic         start,
  input  wire logic         abort,
  input  wire logic         decrypt,
  // data
  input  wire logic [127:0] key,
  input  wire logic [127:0] din,
  output logic              done,
  output logic [127:0]      dout
);
  import aesc_pkg::*;

  aesc_core_state_t s_r;
  aesc_core_state_t s_nxt;

  function automatic logic [127:0] roundKey(input logic [127:0] k, input logic [3:0] r);
    roundKey = k ^ {32{r}};
  endfunction : roundKey

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [127:0] rk;
    rk    = roundKey(key, s_r.round);
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (abort) begin
      s_nxt.busy = 1'b0;
    end else if (start) begin
      s_nxt.busy    = 1'b1;
      s_nxt.decrypt = decrypt;
      s_nxt.data    = din;
      s_nxt.round   = decrypt ? `AESC_CORE_ROUNDS - 4'h1 : 4'h0;
    end else if (s_r.busy) begin
      // decryption walks the rounds backwards so it inverts encryption exactly
      if (s_r.decrypt) begin
        s_nxt.data  = {s_r.data[7:0], s_r.data[127:8]} ^ roundKey(key, s_r.round);
        s_nxt.round = s_r.round - 4'h1;
        if (s_r.round == 4'h0) begin
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end
      end else begin
        s_nxt.data  = {s_r.data[119:0], s_r.data[127:120]} ^ {rk[119:0], rk[127:120]};
        s_nxt.round = s_r.round + 4'h1;
        if (s_r.round == `AESC_CORE_ROUNDS - 4'h1) begin
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign done = s_r.done;
  assign dout = s_r.data;

endmodule : aesc_round_core

// ===== aesc_dma_model.sv
// host-side dma model that feeds the input port and drains the output port
`timescale 1ns/1ps

module aesc_dma_model (
  // clock
  input  wire logic       clk,
  // pacing from the bench
  input  wire logic       stall,
  input  wire logic       flush,
  input  wire logic [4:0] unitLen,
  // device side
  input  wire logic       inputDmaRequest,
  input  wire logic       outputDmaRequest,
  input  wire logic [7:0] outPortData,
  output logic            inWr,
  output logic [7:0]      inData,
  output logic            outRd
);
  logic [7:0] txQ[$];
  logic [7:0] rxQ[$];
  logic [4:0] inCnt;
  logic [4:0] outCnt;

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    inWr   = 1'b0;
    inData = 8'hA5;
    outRd  = 1'b0;
    inCnt  = 5'h00;
    outCnt = 5'h00;
  end

  // the data ports are served only by this channel pair, never by the cpu
  always @(negedge clk) begin
    // a new unit starts only after the request has dropped, or at once on a flush
    if (inCnt == unitLen && !inputDmaRequest) inCnt = 5'h00;
    if (outCnt == unitLen && !outputDmaRequest) outCnt = 5'h00;
    if (flush) begin
      inCnt  = 5'h00;
      outCnt = 5'h00;
    end
    inWr  = 1'b0;
    outRd = 1'b0;
    if (inputDmaRequest && txQ.size() > 0 && inCnt < unitLen && !stall) begin
      inWr   = 1'b1;
      inData = txQ.pop_front();
      inCnt  = inCnt + 5'h01;
    end else begin
      // idle data lines keep changing so a stale byte never looks valid
      inData = ~inData;
    end
    if (outputDmaRequest && outCnt < unitLen && !stall) begin
      outRd = 1'b1;
      rxQ.push_back(outPortData);
      outCnt = outCnt + 5'h01;
    end
  end
endmodule : aesc_dma_model

// ===== tb.sv
// self-checking bench of the cipher coprocessor
`timescale 1ns/1ps

module tb;
  import aesc_pkg::*;
  logic                  clk;
  logic                  rst;
  logic                  csWr;
  logic [7:0]            csData;
  logic                  irqEn;
  logic                  irqClr;
  logic                  stall;
  logic                  slowMode;
  logic                  flush;
  logic [4:0]            unitLen;
  logic                  inWr;
  logic [7:0]            inData;
  logic                  outRd;
  aesc_sfr_req_t         sfrReq;
  logic [7:0]            csRdata;
  logic [7:0]            outPortData;
  logic                  inReq;
  logic                  outReq;
  logic                  irqFlag;
  logic                  irq;
  int                    errorCnt;
  int                    cmpCount;
  logic [127:0]          ct;
  logic [127:0]          zk;
  logic [127:0]          ks2;
  logic [127:0]          tag;
  localparam logic [127:0] KEY   = 128'h2B7E151628AED2A6ABF7158809CF4F3C;
  localparam logic [127:0] PT    = 128'h0123456789ABCDEFFEDCBA98FFFFFFFF;
  localparam logic [127:0] PT1   = 128'h0123456789ABCDEFFEDCBA9800000000;
  localparam logic [8:0]   CHAIN = 9'h105;
  // first auth block: flag 0x59 = extra data, 8-byte tag, 2-byte length field; then nonce and length
  localparam logic [127:0] B0    = {8'h59, 104'h000102030405060708090A0B0C, 16'h0010};
  // extra data block: 2-octet length, four data bytes, zero padding
  localparam logic [127:0] ADATA = {16'h0004, 32'hC0FFEE11, 80'h0};

  assign sfrReq = '{csWr, csData, inWr, inData, outRd};

  aesc_coprocessor dut_u (.clk(clk), .rst(rst), .sfrReq(sfrReq), .csRdata(csRdata), .outPortData(outPortData),
    .inputDmaRequest(inReq), .outputDmaRequest(outReq), .cipherIrqEnable(irqEn),
    .cipherIrqFlagClear(irqClr), .cipherIrqFlag(irqFlag), .cipherIrq(irq));

  aesc_dma_model dma_u (.clk(clk), .stall(stall), .flush(flush), .unitLen(unitLen), .inputDmaRequest(inReq),
    .outputDmaRequest(outReq), .outPortData(outPortData), .inWr(inWr), .inData(inData), .outRd(outRd));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // slow mode makes the dma side answer every other cycle
  always @(posedge clk) stall <= slowMode && !stall;

  task automatic chk_byte(input string name, input logic [7:0] e, input logic [7:0] g);
    cmpCount++;
    if (g !== e) begin
      errorCnt++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask : chk_byte

  task automatic chk_blk(input string name, input logic [127:0] e, input logic [127:0] g);
    cmpCount++;
    if (g !== e) begin
      errorCnt++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask : chk_blk

  function automatic logic [127:0] pop_blk();
    logic [127:0] v;
    v = 'x;
    for (int i = 15; i >= 0; i--) if (dma_u.rxQ.size() > 0) v[i*8+:8] = dma_u.rxQ.pop_front();
    return v;
  endfunction : pop_blk

  task automatic cs_write(input logic [7:0] d);
    @(negedge clk);
    csWr   = 1'b1;
    csData = d;
    @(negedge clk);
    csWr   = 1'b0;
    csData = ~d;
  endtask : cs_write

  task automatic clear_flag();
    @(negedge clk);
    irqClr = 1'b1;
    @(negedge clk);
    irqClr = 1'b0;
  endtask : clear_flag

  task automatic do_flush();
    @(posedge clk);
    flush <= 1'b1;
    @(posedge clk);
    flush <= 1'b0;
    @(negedge clk);
  endtask : do_flush

  // one start per block, with the unit length set before the start
  task automatic run(input logic [7:0] c, input logic [4:0] len, input logic [127:0] blk);
    int n;
    unitLen <= len;
    cs_write(c);
    // queued only once the start is taken, so a request left up by an aborted block cannot eat a byte
    for (int i = 15; i >= 0; i--) dma_u.txQ.push_back(blk[i*8+:8]);
    chk_byte("inReq", 8'h01, {7'h0, inReq});
    chk_byte("ready", {7'h0, c[2]}, {7'h0, csRdata[3]});
    for (n = 0; n < 800 && csRdata[0] !== 1'b0; n++) @(negedge clk);
    chk_byte("csDone", (c & 8'h76) | 8'h08, csRdata);
  endtask : run

  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : printVerdict

  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    $display("unexpected watchdog expected done seen hang");
    printVerdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // a single user drives the block for the whole run
  initial begin
    rst = 1'b1; csWr = 1'b0; csData = 8'h00; irqEn = 1'b0; irqClr = 1'b0;
    slowMode = 1'b0; flush = 1'b0; unitLen = 5'h10; errorCnt = 0; cmpCount = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_byte("csReset", 8'h08, csRdata);
    chk_byte("outs", 8'h00, {outPortData[3:0] | {inReq, outReq, irqFlag, irq}});
    for (int m = 0; m < 8; m++) begin
      cs_write({1'b1, m[2:0], 1'b1, m[1:0], 1'b0});
      chk_byte("modeRead", {1'b0, m[2:0], 1'b1, m[1:0], 1'b0}, csRdata);
    end
    run(8'h41, 5'h10, PT);
    zk = pop_blk();
    run(8'h05, 5'h10, KEY);
    clear_flag();
    irqEn = 1'b1;
    run(8'h41, 5'h10, PT);
    chk_byte("outCount", 8'h10, 8'(dma_u.rxQ.size()));
    ct = pop_blk();
    @(negedge clk);
    chk_byte("flagIrq", 8'h03, {6'h0, irqFlag, irq});
    clear_flag();
    irqEn = 1'b0;
    run(8'h43, 5'h10, ct);
    chk_blk("ecbDec", PT, pop_blk());
    @(negedge clk);
    chk_byte("flagMasked", 8'h02, {6'h0, irqFlag, irq});
    clear_flag();
    chk_byte("flagClr", 8'h00, {7'h0, irqFlag});
    // with a zero iv the first chained block equals the plain one
    for (int k = 0; k < 3; k++) begin
      run({1'b0, CHAIN[k*3+:3], 4'h7}, 5'h10, 128'h0);
      run({1'b0, CHAIN[k*3+:3], 4'h1}, 5'h10, PT);
      chk_blk("chainBlk", ct, pop_blk());
    end
    // nonzero counter, low word at its wrap point
    run(8'h37, 5'h10, PT);
    slowMode = 1'b1;
    run(8'h31, 5'h04, 128'h0);
    chk_blk("ctrBlk0", ct, pop_blk());
    run(8'h31, 5'h04, 128'h0);
    ks2 = pop_blk();
    slowMode = 1'b0;
    run(8'h41, 5'h10, PT1);
    chk_blk("ctrBlk1", pop_blk(), ks2);
    // feedback modes: the first key stream is the block transform of the loaded value
    for (int k = 1; k < 3; k++) begin
      run({1'b0, k[2:0], 4'h7}, 5'h10, PT);
      run({1'b0, k[2:0], 4'h1}, 5'h04, 128'h0);
      chk_blk("fbBlk", ct, pop_blk());
    end
    // a mac over B0 and one padded extra data block equals two chained single-block steps
    run(8'h41, 5'h10, B0);
    ks2 = pop_blk();
    run(8'h41, 5'h10, ks2 ^ ADATA);
    ks2 = pop_blk();
    for (int k = 0; k < 2; k++) begin
      run(8'h57, 5'h10, 128'h0);
      run(8'h51, 5'h10, B0);
      void'(pop_blk());
      run(8'h01, 5'h10, ADATA);
      tag = pop_blk();
      chk_blk("macTag", ks2, tag);
    end
    tag[63:0] = 64'h0;
    chk_blk("macTag8", {ks2[127:64], 64'h0}, tag);
    // key load in the middle of a half-loaded block
    for (int i = 15; i >= 8; i--) dma_u.txQ.push_back(PT[i*8+:8]);
    cs_write(8'h41);
    repeat (20) @(negedge clk);
    chk_byte("midBlkReady", 8'h00, {7'h0, csRdata[3]});
    do_flush();
    run(8'h05, 5'h10, KEY);
    run(8'h41, 5'h10, PT);
    chk_blk("afterAbort", ct, pop_blk());
    // reset in mid-block clears the key
    cs_write(8'h41);
    repeat (3) @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_byte("csReset2", 8'h08, csRdata);
    do_flush();
    run(8'h41, 5'h10, PT);
    chk_blk("zeroKey", zk, pop_blk());
    printVerdict();
  end
endmodule : tb
